//--- common/mcrcw_cfg.svh
`ifndef MCRCW_CFG_SVH
`define MCRCW_CFG_SVH
// register byte offsets
`define MCRCW_OFS_CW    8'h00
`define MCRCW_OFS_CFG   8'h04
`define MCRCW_OFS_PEND  8'h08
`define MCRCW_OFS_LOG   8'h0C
`define MCRCW_OFS_INDEX 8'h10
// control word field positions
`define MCRCW_CW_IRQ_INDEX_ZERO  15
`define MCRCW_CW_IWA    14
`define MCRCW_CW_IBR    13
`define MCRCW_CW_BUSY   12
`define MCRCW_CW_BLOCK_ACCESSED_FLAG   11
`define MCRCW_CW_DPB    10
`define MCRCW_CW_BROADCAST_SEEN  9
`define MCRCW_CW_ACK    8
`define MCRCW_CW_PAUSE  3
`define MCRCW_CW_PINGPONG_ENABLE   2
// host-writable bits of the control word, any time
`define MCRCW_CW_WR_ANY 16'hF008
// reset values
`define MCRCW_CW_RST    16'h0000
`define MCRCW_CFG_RST   9'h000
`define MCRCW_PEND_RST  3'h0
// config register fields
`define MCRCW_CFG_SIMPLIFIED_MODE_CMD_ENABLE  0
`define MCRCW_CFG_TERMINAL_EXECUTE  1
`define MCRCW_CFG_BCINV 2
`define MCRCW_CFG_EIXZ  4
`define MCRCW_CFG_EIWA  5
`define MCRCW_CFG_EIBR  6
`define MCRCW_CFG_SOFT_RESET  8
// pending / log bit positions
`define MCRCW_IRQ_IXZ   0
`define MCRCW_IRQ_IWA   1
`define MCRCW_IRQ_IBR   2
// broadcast-capable mode subaddresses
`define MCRCW_SA_LO     5'h00
`define MCRCW_SA_HI     5'h1F
`endif

//--- common/mcrcw_pkg.sv
package mcrcw_pkg;
  // command header presented when a command starts
  typedef struct packed {
    logic       tr;        // transmit/receive bit, 0 = receive
    logic [4:0] subaddr;   // subaddress field
    logic [4:0] mode_code; // mode code field
    logic       broadcast; // addressed to broadcast address
  } mcrcw_cmd_t;
  // outcome given when the command completes
  typedef struct packed {
    logic error;   // message ended in error
    logic illegal; // command was illegal
  } mcrcw_done_t;
  // answer to the terminal logic
  typedef struct packed {
    logic applies;      // this control word governs the command
    logic busy;         // answer with busy status
    logic store_data;   // store the mode data word
    logic use_ptr_b;    // ping-pong: use data pointer b
    logic use_pointers; // data pointers are used at all
    logic simple_store; // store inside 4-word descriptor
  } mcrcw_rsp_t;
  // ahb-lite data-phase bookkeeping
  typedef struct packed {
    logic       write; // data phase is a write
    logic [7:0] addr;  // low address bits
  } mcrcw_aphase_t;
endpackage

//--- verif/mcrcw_monitor.sv
// =====
// port-level checks of the control word block
module mcrcw_monitor (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  master_reset_pin_n,
  input wire logic                  hsel,
  input wire logic [1:0]            htrans,
  input wire logic                  hready,
  input wire logic                  hreadyout,
  input wire logic                  cmd_start,
  input wire mcrcw_pkg::mcrcw_cmd_t cmd_info,
  input wire logic                  cmd_done,
  input wire logic                  rsp_valid,
  input wire mcrcw_pkg::mcrcw_rsp_t rsp,
  input wire logic                  message_irq_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  import mcrcw_pkg::*;
  // the pin reset clears state too, so both resets mute the checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst || !master_reset_pin_n);
  // =====
  // command answer, interrupt pin and bus wait state
  a_rsp_after_start: assert property (cmd_start |=> rsp_valid)
    else $error("no answer after command start");
  a_rsp_has_cause: assert property (rsp_valid |-> $past(cmd_start))
    else $error("answer without command start");
  a_reject_transmit: assert property (cmd_start && cmd_info.tr |=> !rsp.applies)
    else $error("transmit command governed");
  a_reject_subaddr: assert property (
    cmd_start && !(cmd_info.subaddr inside {5'h00, 5'h1F}) |=> !rsp.applies)
    else $error("wrong subaddress governed");
  a_busy_no_store: assert property (rsp_valid && rsp.busy |-> !rsp.store_data)
    else $error("data stored while busy");
  a_store_upper_codes: assert property (
    rsp_valid && rsp.store_data |-> $past(cmd_info.mode_code[4]))
    else $error("data stored for low mode code");
  a_simple_no_ptr: assert property (rsp_valid && rsp.simple_store |-> !rsp.use_pointers)
    else $error("pointers used in simplified mode");
  a_rsp_holds: assert property (!cmd_start |=> $stable(rsp))
    else $error("answer changed without a start");
  a_irq_at_done: assert property (
    $rose(message_irq_pin) |-> $past(cmd_done) || $past(cmd_done, 2))
    else $error("interrupt pin rose without completion");
  a_bus_one_wait: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("bus wait state not one cycle");
endmodule // mcrcw_monitor

bind mcrcw_top mcrcw_monitor mon_u (.clk, .rst, .master_reset_pin_n, .hsel, .htrans, .hready,
  .hreadyout, .cmd_start, .cmd_info, .cmd_done, .rsp_valid, .rsp, .message_irq_pin);

//--- verif/mcrcw_term_model.sv
// =====
// terminal command source: starts a command, then reports its completion
module mcrcw_term_model (
  input  wire logic              clk,
  output logic                   cmd_start,
  output mcrcw_pkg::mcrcw_cmd_t  cmd_info,
  output logic                   cmd_done,
  output mcrcw_pkg::mcrcw_done_t done_info
);
  timeunit 1ns;
  timeprecision 1ps;
  import mcrcw_pkg::*;
  // idle until the bench asks for a command
  initial begin
    cmd_start = 1'h0;
    cmd_done  = 1'h0;
    cmd_info  = '0;
    done_info = '0;
  end
  // one command; entered just after a rising edge, returns just after one
  task automatic issue(input mcrcw_cmd_t c, input mcrcw_done_t d);
    cmd_start <= 1'h1;
    cmd_info  <= c;
    @(posedge clk);
    cmd_start <= 1'h0;
    cmd_info  <= ~c;  // header no longer valid: show the inverse, not a stale copy
    @(posedge clk);   // completion never in the same cycle as the start
    cmd_done  <= 1'h1;
    done_info <= d;
    @(posedge clk);
    cmd_done  <= 1'h0;
    done_info <= ~d;
  endtask
endmodule // mcrcw_term_model

//--- verif/mode_cmd_rx_control_word_tb.sv
`include "mcrcw_cfg.svh"
module mode_cmd_rx_control_word_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mcrcw_pkg::*;
  // =====
  // stimulus and observed signals
  logic        clk = 1'h0, rst = 1'h1, master_reset_pin_n = 1'h1;
  logic        hsel = 1'h0, hwrite = 1'h0, hreadyout, hresp;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;           // whole words only
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic        cmd_start, cmd_done, rsp_valid, message_irq_pin;
  mcrcw_cmd_t  cmd_info;
  mcrcw_done_t done_info;
  mcrcw_rsp_t  rsp;
  int          fails = 0, checks_done = 0;
  localparam logic [7:0] cw_a = `MCRCW_OFS_CW, cfg_a = `MCRCW_OFS_CFG;
  localparam logic [7:0] pend_a = `MCRCW_OFS_PEND, idx_a = `MCRCW_OFS_INDEX;
  always #10 clk = ~clk;               // 50 MHz
  mcrcw_top dut_u (.clk, .rst, .master_reset_pin_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cmd_start, .cmd_info, .cmd_done,
    .done_info, .rsp_valid, .rsp, .message_irq_pin);
  mcrcw_term_model term_u (.clk, .cmd_start, .cmd_info, .cmd_done, .done_info);
  // =====
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // single transfer; entered just after a rising edge, ready sampled at the edge itself
  // (design outputs change by non-blocking update, so the edge still shows the old value)
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (!hreadyout);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;                      // data phase holds until ready
    do @(posedge clk); while (!hreadyout);
    rd = hrdata;                       // taken at the edge where ready is high
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'h1, a, d, x);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'h0, a, 32'h0, x);
    chk(x, exp);
  endtask
  task automatic cmd(input logic tr, input logic [4:0] sa, input logic [4:0] mc,
                     input logic bc, input logic [1:0] d);
    term_u.issue({tr, sa, mc, bc}, d);
  endtask
  // pin is a registered level: look one and a half cycles on, at the second falling edge
  task automatic pin_chk(input logic exp);
    repeat (2) @(negedge clk);
    chk(message_irq_pin, exp);
    @(posedge clk);
  endtask
  // =====
  // scenarios
  task automatic t_regs;
    rc(cw_a, 32'h0);
    rc(8'hFC, 32'h0);                  // unmapped place reads zero
    wr(cw_a, 32'hFFFF);
    chk(hresp, 1'h0);
    rc(cw_a, 32'hF00C);
    wr(cw_a, 32'h4);
    wr(cfg_a, 32'h72);                 // execute on, all global enables
    wr(cw_a, 32'h0);
    rc(cw_a, 32'h104);
  endtask
  task automatic t_pingpong;
    cmd(1'h0, 5'h00, 5'h11, 1'h0, 2'h0);
    chk(rsp, 6'h2A);
    rc(cw_a, 32'hD04);
    rc(cw_a, 32'h504);
    cmd(1'h0, 5'h00, 5'h11, 1'h0, 2'h2); // error ending
    chk(rsp, 6'h2E);
    rc(cw_a, 32'hD04);
    cmd(1'h0, 5'h1F, 5'h11, 1'h0, 2'h1); // illegal command
    rc(cw_a, 32'hD04);
  endtask
  task automatic t_pause;
    wr(cw_a, 32'hC);
    rc(cw_a, 32'h40C);
    cmd(1'h0, 5'h00, 5'h11, 1'h0, 2'h0);
    rc(cw_a, 32'hC0C);
    wr(cw_a, 32'h4);
    rc(cw_a, 32'h504);
  endtask
  task automatic t_busy;
    wr(cw_a, 32'h1004);
    cmd(1'h0, 5'h00, 5'h14, 1'h0, 2'h0);
    chk(rsp, 6'h36);
    rc(cw_a, 32'h1D04);
  endtask
  task automatic t_irq;
    wr(cw_a, 32'h4004);
    cmd(1'h0, 5'h00, 5'h11, 1'h0, 2'h0);
    pin_chk(1'h1);
    rc(pend_a, 32'h2);
    rc(cw_a, 32'h4904);
    wr(pend_a, 32'h2);
    pin_chk(1'h0);
  endtask
  task automatic t_broadcast_seen;
    wr(cw_a, 32'h2004);
    cmd(1'h0, 5'h1F, 5'h01, 1'h1, 2'h0);
    rc(pend_a, 32'h4);
    rc(cw_a, 32'h2F04);
    wr(pend_a, 32'h4);
    wr(cfg_a, 32'h76);                 // broadcast now invalid
    cmd(1'h0, 5'h1F, 5'h01, 1'h1, 2'h0);
    chk(rsp.applies, 1'h0);
    rc(pend_a, 32'h0);
  endtask
  task automatic t_reject;
    logic [4:0] sa [3] = '{5'h00, 5'h05, 5'h1E};
    for (int i = 0; i < 3; i++) begin
      cmd(i == 0, sa[i], 5'h11, 1'h0, 2'h0);
      chk(rsp.applies, 1'h0);
    end
  endtask
  task automatic t_simple;
    wr(cfg_a, 32'h73);                 // simplified mode on
    wr(cw_a, 32'h4000);
    cmd(1'h0, 5'h00, 5'h10, 1'h0, 2'h0);
    chk({rsp.applies, rsp.store_data, rsp.use_pointers, rsp.simple_store}, 4'hD);
    pin_chk(1'h1);
    wr(pend_a, 32'h2);
  endtask
  task automatic t_index;
    wr(cfg_a, 32'h70);                 // stop execution so bit 2 may change
    wr(cw_a, 32'h8000);
    wr(idx_a, 32'h1);
    wr(cfg_a, 32'h72);
    cmd(1'h0, 5'h00, 5'h11, 1'h0, 2'h0);
    rc(pend_a, 32'h1);
    rc(idx_a, 32'h0);
    rc(`MCRCW_OFS_LOG, 32'h21);
  endtask
  task automatic t_resets;
    wr(cfg_a, 32'h172);                // soft reset request
    rc(cw_a, 32'h8000);
    master_reset_pin_n <= 1'h0;
    repeat (6) @(posedge clk);
    master_reset_pin_n <= 1'h1;
    repeat (4) @(posedge clk);
    rc(cw_a, 32'h0);
    rc(cfg_a, 32'h0);
    rc(pend_a, 32'h0);
    pin_chk(1'h0);
  endtask
  // =====
  // verdict and run control
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // whole run needs a few hundred cycles; this is ample margin
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_regs;
    t_pingpong;
    t_pause;
    t_busy;
    t_irq;
    t_broadcast_seen;
    t_reject;
    t_simple;
    t_index;
    t_resets;
    end_of_test;
  end
endmodule // mode_cmd_rx_control_word_tb

//--- verilog/mcrcw_top.sv
`include "mcrcw_cfg.svh"

module mcrcw_top #(
  parameter int IDX_W = 8 // buffer index width
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 master_reset_pin_n,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // terminal command path
  input  wire logic                 cmd_start,
  input  wire mcrcw_pkg::mcrcw_cmd_t  cmd_info,
  input  wire logic                 cmd_done,
  input  wire mcrcw_pkg::mcrcw_done_t done_info,
  output logic                      rsp_valid,
  output mcrcw_pkg::mcrcw_rsp_t     rsp,
  output logic                      message_irq_pin
);
  import mcrcw_pkg::*;

  // ==========================================================
  // reset synchroniser
  // ==========================================================
  logic mr_s1_q;   // first stage, read only by mr_s2_q
  logic mr_s2_q;   // second stage
  logic mr_hit;    // master reset asserted (synchronised)
  logic rst_all;   // pin or system reset

  // pin is asynchronous, so two flops before use
  always_ff @(posedge clk) begin
    if (rst) begin
      mr_s1_q <= 1'b1;
      mr_s2_q <= 1'b1;
    end else begin
      mr_s1_q <= master_reset_pin_n;
      mr_s2_q <= mr_s1_q;
    end
  end

  assign mr_hit  = ~mr_s2_q;
  assign rst_all = rst | mr_hit;

  // ==========================================================
  // storage
  // ==========================================================
  logic [15:0]      cw_q;      // receive mode control word
  logic [15:0]      cw_d;
  logic [8:0]       cfg_q;     // configuration bits
  logic [2:0]       pend_q;    // pending interrupts
  logic [2:0]       pend_set;  // completion events
  logic [2:0]       log_bits_q;// last logged interrupt set
  logic [7:0]       log_cnt_q; // logged event count
  logic [IDX_W-1:0] idx_q;     // buffer index
  logic             sr_q;      // soft reset pulse
  mcrcw_cmd_t       cmd_q;     // command being processed
  logic             rd_cw;     // host reads the control word
  logic             wr_cw;     // host writes the control word

  // ==========================================================
  // ahb-lite slave: one wait state, registered read data
  // ==========================================================
  logic          dph_q;   // data phase in progress
  mcrcw_aphase_t aph_q;   // captured address phase
  logic          accept;  // address phase taken
  logic          wr_now;  // write data applied this cycle
  logic          rd_now;  // read data loaded this cycle
  logic [31:0]   rd_mux;  // selected read value

  assign accept = hsel & htrans[1] & hready;
  assign wr_now = dph_q & ~hreadyout & aph_q.write;
  assign rd_now = dph_q & ~hreadyout & ~aph_q.write;
  assign wr_cw  = wr_now & (aph_q.addr == `MCRCW_OFS_CW);
  assign rd_cw  = rd_now & (aph_q.addr == `MCRCW_OFS_CW);

  // unmapped addresses read zero and ignore writes
  assign rd_mux =
    (aph_q.addr == `MCRCW_OFS_CW)    ? {16'h0000, cw_q} :
    (aph_q.addr == `MCRCW_OFS_CFG)   ? {23'h000000, cfg_q} :
    (aph_q.addr == `MCRCW_OFS_PEND)  ? {29'h00000000, pend_q} :
    (aph_q.addr == `MCRCW_OFS_LOG)   ? {21'h000000, log_cnt_q, log_bits_q} :
    (aph_q.addr == `MCRCW_OFS_INDEX) ? 32'(idx_q) : 32'h00000000;

  // bus handshake; hsize is ignored, only whole words are used
  always_ff @(posedge clk) begin
    if (rst_all) begin
      dph_q     <= 1'b0;
      aph_q     <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
    end else if (dph_q & ~hreadyout) begin
      // wait cycle: act on the transfer, then release
      hreadyout <= 1'b1;
      dph_q     <= 1'b0;
      if (rd_now) begin
        hrdata <= rd_mux;
      end
    end else if (accept) begin
      // stall the data phase one cycle
      dph_q     <= 1'b1;
      aph_q     <= '{write: hwrite, addr: haddr[7:0]};
      hreadyout <= 1'b0;
    end
  end

  // ==========================================================
  // configuration and soft reset
  // ==========================================================
  logic cfg_wr; // config register write
  assign cfg_wr = wr_now & (aph_q.addr == `MCRCW_OFS_CFG);

  // soft reset bit is a self-clearing strobe
  always_ff @(posedge clk) begin
    if (rst_all) begin
      cfg_q <= `MCRCW_CFG_RST;
      sr_q  <= 1'b0;
    end else begin
      sr_q <= cfg_wr & hwdata[`MCRCW_CFG_SOFT_RESET];
      if (cfg_wr) begin
        cfg_q <= {1'b0, hwdata[7:0]};
      end
    end
  end

  logic simplified_mode_cmd_enable;   // simplified mode command processing
  logic terminal_execute;   // terminal execute
  logic bcinv;  // broadcast invalidate
  assign simplified_mode_cmd_enable  = cfg_q[`MCRCW_CFG_SIMPLIFIED_MODE_CMD_ENABLE];
  assign terminal_execute  = cfg_q[`MCRCW_CFG_TERMINAL_EXECUTE];
  assign bcinv = cfg_q[`MCRCW_CFG_BCINV];

  // ==========================================================
  // command decode
  // ==========================================================
  logic cmd_hit;   // start applies to this word
  logic pp_mode;   // ping-pong selected
  logic pp_live;   // ping-pong active (ack high)

  // receive only, subaddress 0 or 1F
  assign cmd_hit = ~cmd_info.tr &
                   ((cmd_info.subaddr == `MCRCW_SA_LO) |
                    (cmd_info.subaddr == `MCRCW_SA_HI)) &
                   ~(cmd_info.broadcast & bcinv);
  // circular modes do not exist here; pingpong_enable or indexed
  assign pp_mode = ~simplified_mode_cmd_enable & cw_q[`MCRCW_CW_PINGPONG_ENABLE];
  assign pp_live = pp_mode & cw_q[`MCRCW_CW_ACK];

  // answer to a start, one cycle later, from flops
  always_ff @(posedge clk) begin
    if (rst_all) begin
      rsp_valid <= 1'b0;
      rsp       <= '0;
      cmd_q     <= '0;
    end else begin
      rsp_valid <= cmd_start;
      if (cmd_start) begin
        cmd_q            <= cmd_info;
        rsp.applies      <= cmd_hit;
        rsp.busy         <= cmd_hit & cw_q[`MCRCW_CW_BUSY];
        rsp.store_data   <= cmd_hit & ~cw_q[`MCRCW_CW_BUSY] &
                            cmd_info.mode_code[4];
        // pointer a or b; with ack low the same buffer is reused
        rsp.use_ptr_b    <= cmd_hit & pp_mode & cw_q[`MCRCW_CW_DPB];
        rsp.use_pointers <= cmd_hit & ~simplified_mode_cmd_enable;
        rsp.simple_store <= cmd_hit & simplified_mode_cmd_enable &
                            cmd_info.mode_code[4];
      end
    end
  end

  // ==========================================================
  // completion events
  // ==========================================================
  logic done_hit;  // completion of a governed command
  logic done_ok;   // clean completion
  logic done_bc;   // valid broadcast completion
  logic toggle;    // ping-pong pointer flips
  logic idx_dec;   // indexed mode index steps down
  logic idx_one;   // index at one before stepping

  assign done_hit = cmd_done & rsp.applies;
  assign done_ok  = done_hit & ~done_info.error & ~done_info.illegal;
  assign done_bc  = done_ok & cmd_q.broadcast;
  // error, illegal and busy leave the pointer; ack low freezes it
  assign toggle   = done_ok & ~rsp.busy & pp_live;
  assign idx_dec  = done_ok & ~rsp.busy & ~simplified_mode_cmd_enable & ~pp_mode &
                    (idx_q != '0);
  assign idx_one  = (idx_q == IDX_W'(1));

  // interrupt sources; same terms whether simplified or not, except index zero, which needs simplified mode off
  assign pend_set[`MCRCW_IRQ_IXZ] = idx_dec & idx_one &
    cw_q[`MCRCW_CW_IRQ_INDEX_ZERO] & cfg_q[`MCRCW_CFG_EIXZ];
  assign pend_set[`MCRCW_IRQ_IWA] = done_ok &
    cw_q[`MCRCW_CW_IWA] & cfg_q[`MCRCW_CFG_EIWA];
  assign pend_set[`MCRCW_IRQ_IBR] = done_bc &
    cw_q[`MCRCW_CW_IBR] & cfg_q[`MCRCW_CFG_EIBR];

  // ==========================================================
  // control word next value
  // ==========================================================
  always_comb begin
    cw_d = cw_q;
    // host side: bits 8-11 never taken from the bus
    if (wr_cw) begin
      cw_d = (cw_q & ~`MCRCW_CW_WR_ANY) |
             (hwdata[15:0] & `MCRCW_CW_WR_ANY);
      if (~terminal_execute) begin
        cw_d[`MCRCW_CW_PINGPONG_ENABLE] = hwdata[`MCRCW_CW_PINGPONG_ENABLE];
      end
    end
    // read side effect; a same-cycle completion wins below
    if (rd_cw) begin
      cw_d[`MCRCW_CW_BLOCK_ACCESSED_FLAG] = 1'b0;
    end
    // soft reset touches only three status bits
    if (sr_q) begin
      cw_d[`MCRCW_CW_BLOCK_ACCESSED_FLAG]  = 1'b0;
      cw_d[`MCRCW_CW_DPB]   = 1'b0;
      cw_d[`MCRCW_CW_BROADCAST_SEEN] = 1'b0;
    end
    // device updates only while the terminal executes
    if (terminal_execute) begin
      // ack tracks ping-pong selected and the pause request
      cw_d[`MCRCW_CW_ACK] = pp_mode & ~cw_q[`MCRCW_CW_PAUSE];
      // all status bits land in the same cycle
      if (done_hit) begin
        cw_d[`MCRCW_CW_BLOCK_ACCESSED_FLAG] = 1'b1;
      end
      if (done_bc) begin
        cw_d[`MCRCW_CW_BROADCAST_SEEN] = 1'b1;
      end
      if (toggle) begin
        cw_d[`MCRCW_CW_DPB] = ~cw_q[`MCRCW_CW_DPB];
      end
    end
    // unused bits stay zero; no circular-mode bits exist
    cw_d[7:4] = 4'h0;
    cw_d[1:0] = 2'h0;
  end

  // master reset clears the whole word
  always_ff @(posedge clk) begin
    if (rst_all) begin
      cw_q <= `MCRCW_CW_RST;
    end else begin
      cw_q <= cw_d;
    end
  end

  // ==========================================================
  // buffer index: host loads, indexed completions count down
  // ==========================================================
  logic idx_wr; // index register write
  assign idx_wr = wr_now & (aph_q.addr == `MCRCW_OFS_INDEX);

  always_ff @(posedge clk) begin
    if (rst_all) begin
      idx_q <= '0;
    end else if (idx_dec) begin
      // device step beats a colliding host load
      idx_q <= idx_q - IDX_W'(1);
    end else if (idx_wr) begin
      idx_q <= hwdata[IDX_W-1:0];
    end
  end

  // ==========================================================
  // pending interrupts, write one to clear, set wins
  // ==========================================================
  logic pend_wr; // pending register write
  assign pend_wr = wr_now & (aph_q.addr == `MCRCW_OFS_PEND);

  for (genvar i = 0; i < 3; i++) begin : g_pend
    always_ff @(posedge clk) begin
      if (rst_all) begin
        pend_q[i] <= 1'b0;
      end else if (pend_set[i]) begin
        pend_q[i] <= 1'b1;
      end else if (pend_wr & hwdata[i]) begin
        pend_q[i] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // interrupt log and message interrupt pin
  // ==========================================================
  // only the latest event is kept; the count wraps silently
  always_ff @(posedge clk) begin
    if (rst_all) begin
      log_bits_q      <= `MCRCW_PEND_RST;
      log_cnt_q       <= 8'h00;
      message_irq_pin <= 1'b0;
    end else begin
      if (|pend_set) begin
        log_bits_q <= pend_set;
        log_cnt_q  <= log_cnt_q + 8'h01;
      end
      // pin raised with the status update
      message_irq_pin <= (|pend_set) | (|(pend_q & ~({3{pend_wr}} & hwdata[2:0])));
    end
  end

endmodule // mcrcw_top
